/* File: src/liucfg_pkg.sv */
package liucfg_pkg;

    // ------------------------------------------------------------
    // sizes and clocking
    // ------------------------------------------------------------
    localparam int NUM_CH        = 8;
    localparam int CH_W          = 3;
    localparam int CLK_PERIOD_NS = 100;
    localparam int SYS_CLK_KHZ   = 10000;
    localparam int MCLK_E1_KHZ   = 2048;
    localparam int MCLK_T1_KHZ   = 1544;
    localparam int NCO_W         = 24;

    // phase increments of the master clock synthesizer, rounded to nearest
    localparam logic [NCO_W-1:0] NCO_INC_E1 =
        NCO_W'(((64'(MCLK_E1_KHZ) << NCO_W) + 64'(SYS_CLK_KHZ / 2)) / 64'(SYS_CLK_KHZ));
    localparam logic [NCO_W-1:0] NCO_INC_T1 =
        NCO_W'(((64'(MCLK_T1_KHZ) << NCO_W) + 64'(SYS_CLK_KHZ / 2)) / 64'(SYS_CLK_KHZ));

    // a reference with no edge for this long counts as lost (least time, rounded up)
    localparam int         REF_TIMEOUT_NS  = 1600;
    localparam int         REF_TIMEOUT_INT = (REF_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] REF_TIMEOUT_CYC = 8'(REF_TIMEOUT_INT);

    // ------------------------------------------------------------
    // clock select and rate codes
    // ------------------------------------------------------------
    localparam logic [2:0] CLKSEL_E1REF = 3'h0;
    localparam logic [2:0] CLKSEL_T1REF = 3'h1;
    localparam logic       RATE_E1      = 1'h0;
    localparam logic       RATE_T1      = 1'h1;

    // ------------------------------------------------------------
    // termination and resistor encodings, values in ohms
    // ------------------------------------------------------------
    localparam logic [1:0] TERM_SEL_100 = 2'h0;
    localparam logic [1:0] TERM_SEL_110 = 2'h1;
    localparam logic [1:0] TERM_SEL_75  = 2'h2;
    localparam logic [1:0] TERM_SEL_120 = 2'h3;
    localparam logic [7:0] OHM_100      = 8'h64;
    localparam logic [7:0] OHM_110      = 8'h6e;
    localparam logic [7:0] OHM_75       = 8'h4b;
    localparam logic [7:0] OHM_120      = 8'h78;
    localparam logic [1:0] EXT_RES_NONE = 2'h0;
    localparam logic [1:0] EXT_RES_240  = 2'h1;
    localparam logic [1:0] EXT_RES_210  = 2'h2;
    localparam logic [1:0] EXT_RES_150  = 2'h3;
    localparam logic [7:0] OHM_NONE     = 8'h00;
    localparam logic [7:0] OHM_240      = 8'hf0;
    localparam logic [7:0] OHM_210      = 8'hd2;
    localparam logic [7:0] OHM_150      = 8'h96;

    // ------------------------------------------------------------
    // per-channel configuration word
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        LOOP_NONE    = 3'h0,
        LOOP_REMOTE  = 3'h1,
        LOOP_ANALOG  = 3'h2,
        LOOP_DIGITAL = 3'h3,
        LOOP_DUAL    = 3'h4
    } liucfg_loop_t;

    typedef struct packed {
        logic [1:0]   ext_resistor_sel;
        logic [1:0]   termination_impedance_sel;
        logic [4:0]   equalizer_pulse_ctrl;
        logic [1:0]   jitter_atten_sel;
        logic         rx_termination_enable;
        logic         tx_termination_enable;
        logic         tx_all_ones;
        logic         qrss_enable;
        liucfg_loop_t loopback;
    } liucfg_chan_t;

    localparam liucfg_chan_t CHAN_RESET = '{
        ext_resistor_sel:          EXT_RES_NONE,
        termination_impedance_sel: TERM_SEL_100,
        equalizer_pulse_ctrl:      5'h00,
        jitter_atten_sel:          2'h0,
        rx_termination_enable:     1'h0,
        tx_termination_enable:     1'h0,
        tx_all_ones:               1'h0,
        qrss_enable:               1'h0,
        loopback:                  LOOP_NONE
    };

endpackage

/* File: src/liucfg_clk_if.sv */
`timescale 1ns/1ns
interface liucfg_clk_if;
    logic       rate;
    logic [2:0] sel;
    logic       e1_ref;
    logic       t1_ref;
    logic       master_clk;
    logic       sel_valid;
    logic       ref_lost;

    modport gen  (input rate, sel, e1_ref, t1_ref, output master_clk, sel_valid, ref_lost);
    modport user (output rate, sel, e1_ref, t1_ref, input master_clk, sel_valid, ref_lost);
endinterface

/* File: src/liucfg_clkgen.sv */
`timescale 1ns/1ns
module liucfg_clkgen (
    input wire logic       clock_i,
    input wire logic       reset_i,
    liucfg_clk_if.gen      clk_if
);
    import liucfg_pkg::*;

    logic [NCO_W-1:0] acc_reg,  acc_next;
    logic             mclk_reg, mclk_next;
    logic             last_ref_reg, last_ref_next;
    logic [7:0]       idle_reg, idle_next;
    logic             lost_reg, lost_next;
    logic             valid_reg, valid_next;
    logic             ref_now;
    logic             run;

    // ------------------------------------------------------------
    // reference watch and synthesizer
    // ------------------------------------------------------------
    always_comb begin
        valid_next    = (clk_if.sel == CLKSEL_E1REF) || (clk_if.sel == CLKSEL_T1REF);
        ref_now       = (clk_if.sel == CLKSEL_T1REF) ? clk_if.t1_ref : clk_if.e1_ref;
        last_ref_next = ref_now;
        if (ref_now != last_ref_reg) begin
            idle_next = 8'h00;
        end else if (idle_reg == REF_TIMEOUT_CYC) begin
            idle_next = idle_reg;
        end else begin
            idle_next = idle_reg + 8'h01;
        end
        lost_next = (idle_next == REF_TIMEOUT_CYC);
        // a stale reference or unsupported code freezes the phase rather than glitching
        run = valid_reg && !lost_reg;
        acc_next  = run ? acc_reg + ((clk_if.rate == RATE_T1) ? NCO_INC_T1 : NCO_INC_E1) : acc_reg;
        mclk_next = acc_next[NCO_W-1];
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            acc_reg      <= '0;
            mclk_reg     <= 1'h0;
            last_ref_reg <= 1'h0;
            idle_reg     <= 8'h00;
            lost_reg     <= 1'h1;
            valid_reg    <= 1'h0;
        end else begin
            acc_reg      <= acc_next;
            mclk_reg     <= mclk_next;
            last_ref_reg <= last_ref_next;
            idle_reg     <= idle_next;
            lost_reg     <= lost_next;
            valid_reg    <= valid_next;
        end
    end

    assign clk_if.master_clk = mclk_reg;
    assign clk_if.sel_valid  = valid_reg;
    assign clk_if.ref_lost   = lost_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_mclk_toggles: assert property (@(posedge clock_i) disable iff (reset_i)
        // four advances always cross one half period, even at the slower rate
        (valid_reg && !lost_reg) [*4] |=> (mclk_reg != $past(mclk_reg)) || ($past(mclk_reg) != $past(mclk_reg, 2))
            || ($past(mclk_reg, 2) != $past(mclk_reg, 3)) || ($past(mclk_reg, 3) != $past(mclk_reg, 4)))
        else $error("master clock stopped while reference present");
    chk_ref_lost_time: assert property (@(posedge clock_i) disable iff (reset_i)
        (idle_reg == REF_TIMEOUT_CYC - 8'h01 && ref_now == last_ref_reg) |=> lost_reg)
        else $error("reference loss not flagged after timeout");
    chk_bad_sel_halt: assert property (@(posedge clock_i) disable iff (reset_i)
        !valid_reg |=> $stable(mclk_reg))
        else $error("master clock ran under an unsupported select code");
endmodule

/* File: src/liucfg_top.sv */
`timescale 1ns/1ns
module liucfg_top (
    input  wire logic                                          clock_i,
    input  wire logic                                          reset_i,
    input  wire logic                                          host_mode_i,
    input  wire logic                                          cfg_wr_i,
    input  wire logic [liucfg_pkg::CH_W-1:0]                   cfg_chan_i,
    input  wire liucfg_pkg::liucfg_chan_t                      cfg_data_i,
    input  wire liucfg_pkg::liucfg_chan_t                      hw_cfg_i,
    input  wire logic                                          rx_term_pin_override_i,
    input  wire logic                                          rx_term_pin_i,
    input  wire logic                                          master_rate_bit_i,
    input  wire logic                                          ref_freq_select_b2_i,
    input  wire logic                                          ref_freq_select_b1_i,
    input  wire logic                                          ref_freq_select_b0_i,
    input  wire logic                                          e1_ref_clock_in_i,
    input  wire logic                                          t1_ref_clock_in_i,
    output liucfg_pkg::liucfg_chan_t [liucfg_pkg::NUM_CH-1:0]  ch_cfg_o,
    output logic [liucfg_pkg::NUM_CH-1:0][7:0]                 ch_term_ohm_o,
    output logic [liucfg_pkg::NUM_CH-1:0][7:0]                 ch_ext_res_ohm_o,
    output logic                                               line_rate_t1_o,
    output logic                                               master_clk_o,
    output logic                                               clk_sel_valid_o,
    output logic                                               ref_lost_o
);
    import liucfg_pkg::*;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] term_ohms(input logic [1:0] sel);
        logic [7:0] r;
        r = OHM_100;
        unique case (sel)
            TERM_SEL_100: r = OHM_100;
            TERM_SEL_110: r = OHM_110;
            TERM_SEL_75:  r = OHM_75;
            TERM_SEL_120: r = OHM_120;
        endcase
        return r;
    endfunction

    function automatic logic [7:0] ext_ohms(input logic [1:0] sel);
        logic [7:0] r;
        r = OHM_NONE;
        unique case (sel)
            EXT_RES_NONE: r = OHM_NONE;
            EXT_RES_240:  r = OHM_240;
            EXT_RES_210:  r = OHM_210;
            EXT_RES_150:  r = OHM_150;
        endcase
        return r;
    endfunction

    // strips features that hardware mode cannot offer
    function automatic liucfg_chan_t mode_limit(input logic host, input liucfg_chan_t c);
        liucfg_chan_t r;
        r = c;
        if (!host) begin
            r.qrss_enable = 1'h0;
            if (c.loopback == LOOP_DUAL) begin
                r.loopback = LOOP_NONE;
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // per-channel store, host mode only
    // ------------------------------------------------------------
    liucfg_chan_t store_reg [NUM_CH];
    liucfg_chan_t store_next [NUM_CH];
    // hardware mode leaves the store alone, so host settings survive a mode switch

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            store_next[i] = store_reg[i];
        end
        if (host_mode_i && cfg_wr_i) begin
            store_next[cfg_chan_i] = cfg_data_i;
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < NUM_CH; i++) begin
                store_reg[i] <= CHAN_RESET;
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                store_reg[i] <= store_next[i];
            end
        end
    end

    // ------------------------------------------------------------
    // effective channel settings
    // ------------------------------------------------------------
    liucfg_chan_t [NUM_CH-1:0] out_reg, out_next;
    logic [NUM_CH-1:0][7:0]    term_reg, term_next;
    logic [NUM_CH-1:0][7:0]    ext_reg, ext_next;
    logic                      rate_reg, rate_next;
    liucfg_chan_t              pick;

    always_comb begin
        pick = CHAN_RESET;
        for (int i = 0; i < NUM_CH; i++) begin
            pick = mode_limit(host_mode_i, host_mode_i ? store_reg[i] : hw_cfg_i);
            if (rx_term_pin_override_i) begin
                pick.rx_termination_enable = rx_term_pin_i;
            end
            out_next[i]  = pick;
            term_next[i] = term_ohms(pick.termination_impedance_sel);
            ext_next[i]  = ext_ohms(pick.ext_resistor_sel);
        end
        rate_next = master_rate_bit_i;
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            out_reg  <= {NUM_CH{CHAN_RESET}};
            term_reg <= {NUM_CH{OHM_100}};
            ext_reg  <= {NUM_CH{OHM_NONE}};
            rate_reg <= RATE_E1;
        end else begin
            out_reg  <= out_next;
            term_reg <= term_next;
            ext_reg  <= ext_next;
            rate_reg <= rate_next;
        end
    end

    // enable bit reaches the receiver switch through out_reg, one clock after the pin or store changes
    assign ch_cfg_o         = out_reg;
    assign ch_term_ohm_o    = term_reg;
    assign ch_ext_res_ohm_o = ext_reg;
    assign line_rate_t1_o   = rate_reg;

    // ------------------------------------------------------------
    // master clock generator
    // ------------------------------------------------------------
    liucfg_clk_if clk_bus ();

    // both references offered to the synthesizer
    assign clk_bus.rate   = rate_reg;
    assign clk_bus.sel    = {ref_freq_select_b2_i, ref_freq_select_b1_i, ref_freq_select_b0_i};
    assign clk_bus.e1_ref = e1_ref_clock_in_i;
    assign clk_bus.t1_ref = t1_ref_clock_in_i;

    liucfg_clkgen u_clkgen (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .clk_if  (clk_bus.gen)
    );

    assign master_clk_o    = clk_bus.master_clk;
    assign clk_sel_valid_o = clk_bus.sel_valid;
    assign ref_lost_o      = clk_bus.ref_lost;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);

    sequence s_hw_steady;
        (!host_mode_i && !rx_term_pin_override_i) [*2];
    endsequence

    sequence s_override_on;
        rx_term_pin_override_i;
    endsequence

    chk_rate_follows: assert property (
        ##1 line_rate_t1_o == $past(master_rate_bit_i))
        else $error("line rate does not follow rate bit");

    // the first edge after release still shows the reset values
    chk_rst_clk_idle: assert property (
        $fell(reset_i) |-> !master_clk_o && !clk_sel_valid_o && ref_lost_o && !line_rate_t1_o)
        else $error("clock outputs not at reset values");

    for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
        sequence s_write_ch;
            host_mode_i && cfg_wr_i && cfg_chan_i == CH_W'(g);
        endsequence

        chk_hw_no_qrss: assert property (
            !host_mode_i |=> !ch_cfg_o[g].qrss_enable && ch_cfg_o[g].tx_all_ones == $past(hw_cfg_i.tx_all_ones))
            else $error("qrss active or all-ones lost in hardware mode");
        chk_hw_global_res: assert property (
            !host_mode_i |=> ch_cfg_o[g].ext_resistor_sel == $past(hw_cfg_i.ext_resistor_sel))
            else $error("resistor select not global in hardware mode");
        chk_hw_global_ter: assert property (
            !host_mode_i |=> ch_cfg_o[g].termination_impedance_sel == $past(hw_cfg_i.termination_impedance_sel))
            else $error("impedance select not global in hardware mode");
        chk_hw_global_eq: assert property (
            !host_mode_i |=> ch_cfg_o[g].equalizer_pulse_ctrl == $past(hw_cfg_i.equalizer_pulse_ctrl))
            else $error("equalizer control not global in hardware mode");
        chk_hw_no_dual: assert property (
            !host_mode_i |=> ch_cfg_o[g].loopback != LOOP_DUAL)
            else $error("dual loopback in hardware mode");
        chk_hw_global_ja: assert property (
            !host_mode_i |=> ch_cfg_o[g].jitter_atten_sel == $past(hw_cfg_i.jitter_atten_sel))
            else $error("jitter select not global in hardware mode");
        chk_hw_rx_term: assert property (
            (!host_mode_i && !rx_term_pin_override_i)
                |=> ch_cfg_o[g].rx_termination_enable == $past(hw_cfg_i.rx_termination_enable))
            else $error("rx termination not global in hardware mode");
        chk_hw_tx_term: assert property (
            !host_mode_i |=> ch_cfg_o[g].tx_termination_enable == $past(hw_cfg_i.tx_termination_enable))
            else $error("tx termination not global in hardware mode");
        chk_term_decode: assert property (
            ch_cfg_o[g].termination_impedance_sel == TERM_SEL_75 |-> ch_term_ohm_o[g] == OHM_75)
            else $error("impedance decode wrong");
        chk_pin_override: assert property (
            s_override_on |=> ch_cfg_o[g].rx_termination_enable == $past(rx_term_pin_i))
            else $error("termination pin did not override");
        chk_pin_ignored: assert property (
            s_hw_steady ##0 $changed(rx_term_pin_i) |=> $stable(ch_cfg_o[g].rx_termination_enable)
                || $past(hw_cfg_i.rx_termination_enable) != $past(hw_cfg_i.rx_termination_enable, 2))
            else $error("termination pin acted while ignored");
        chk_res_decode: assert property (
            ch_cfg_o[g].ext_resistor_sel == EXT_RES_240 |-> ch_ext_res_ohm_o[g] == OHM_240)
            else $error("resistor decode wrong");
        chk_host_store: assert property (
            (s_write_ch ##1 (host_mode_i && !(cfg_wr_i && cfg_chan_i == CH_W'(g))))
                |=> ch_cfg_o[g].equalizer_pulse_ctrl == $past(cfg_data_i.equalizer_pulse_ctrl, 2))
            else $error("per-channel write not reflected");
        chk_rst_term_off: assert property (
            $fell(reset_i) |-> !ch_cfg_o[g].rx_termination_enable || rx_term_pin_override_i)
            else $error("termination enabled out of reset");

        // ------------------------------------------------------------
        // full decode tables and hardware-mode sharing
        // ------------------------------------------------------------
        chk_term_table: assert property (
            (ch_cfg_o[g].termination_impedance_sel == TERM_SEL_100 && ch_term_ohm_o[g] == OHM_100)
            || (ch_cfg_o[g].termination_impedance_sel == TERM_SEL_110 && ch_term_ohm_o[g] == OHM_110)
            || (ch_cfg_o[g].termination_impedance_sel == TERM_SEL_75 && ch_term_ohm_o[g] == OHM_75)
            || (ch_cfg_o[g].termination_impedance_sel == TERM_SEL_120 && ch_term_ohm_o[g] == OHM_120))
            else $error("impedance decode outside table");

        chk_res_table: assert property (
            (ch_cfg_o[g].ext_resistor_sel == EXT_RES_NONE && ch_ext_res_ohm_o[g] == OHM_NONE)
            || (ch_cfg_o[g].ext_resistor_sel == EXT_RES_240 && ch_ext_res_ohm_o[g] == OHM_240)
            || (ch_cfg_o[g].ext_resistor_sel == EXT_RES_210 && ch_ext_res_ohm_o[g] == OHM_210)
            || (ch_cfg_o[g].ext_resistor_sel == EXT_RES_150 && ch_ext_res_ohm_o[g] == OHM_150))
            else $error("resistor decode outside table");

        chk_rst_res_none: assert property (
            $fell(reset_i) |-> ch_cfg_o[g].ext_resistor_sel == EXT_RES_NONE && ch_ext_res_ohm_o[g] == OHM_NONE)
            else $error("external resistor selected out of reset");
        chk_hw_same_all: assert property (
            !host_mode_i |=> ch_cfg_o[g] == ch_cfg_o[0])
            else $error("channels differ in hardware mode");

        chk_hw_drop_write: assert property (
            !host_mode_i && cfg_wr_i |=> store_reg[g] == $past(store_reg[g]))
            else $error("write taken in hardware mode");
        chk_hw_loop_kept: assert property (
            !host_mode_i && hw_cfg_i.loopback != LOOP_DUAL |=> ch_cfg_o[g].loopback == $past(hw_cfg_i.loopback))
            else $error("loopback mode lost in hardware mode");
    end
endmodule

/* File: tb/liucfg_ref_model.sv */
`timescale 1ns/1ns
module liucfg_ref_model (
    input  wire logic e1_en_i,
    input  wire logic t1_en_i,
    output logic      e1_ref_o,
    output logic      t1_ref_o
);
    // ------------------------------------------------
    // reference sources
    // ------------------------------------------------
    // a stopped source holds its level, as a dead oscillator would
    // half periods chosen so that no toggle lands on a rising clock edge
    // two independent references
    initial begin
        e1_ref_o = 1'b0;
        forever #260 if (e1_en_i) e1_ref_o = ~e1_ref_o;
    end
    initial begin
        t1_ref_o = 1'b0;
        forever #340 if (t1_en_i) t1_ref_o = ~t1_ref_o;
    end
endmodule

/* File: tb/liucfg_top_tb_top.sv */
`timescale 1ns/1ns
module liucfg_top_tb_top;
    import liucfg_pkg::*;
    // ------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------
    logic                      clock_i    = 1'b0;
    logic                      reset_i    = 1'b1;
    logic                      host_mode  = 1'b1;
    logic                      wr         = 1'b0;
    logic [CH_W-1:0]           chan       = '0;
    liucfg_chan_t              data       = CHAN_RESET;
    liucfg_chan_t              hw         = CHAN_RESET;
    logic                      term_ovr   = 1'b0;
    logic                      term_pin   = 1'b0;
    logic                      rate       = 1'b0;
    logic [2:0]                sel        = 3'h0;
    logic                      e1_en      = 1'b1;
    logic                      t1_en      = 1'b1;
    logic                      e1_ref;
    logic                      t1_ref;
    liucfg_chan_t [NUM_CH-1:0] ch_cfg;
    logic [NUM_CH-1:0][7:0]    term_ohm;
    logic [NUM_CH-1:0][7:0]    ext_ohm;
    logic                      rate_t1;
    logic                      mclk;
    logic                      sel_ok;
    logic                      lost;
    int                        n_errors    = 0;
    int                        comparisons = 0;
    logic [7:0]                term_tab [4] = '{OHM_100, OHM_110, OHM_75, OHM_120};
    logic [7:0]                ext_tab  [4] = '{OHM_NONE, OHM_240, OHM_210, OHM_150};

    always #50 clock_i = ~clock_i;

    liucfg_ref_model liucfg_ref_model_inst (.e1_en_i(e1_en), .t1_en_i(t1_en), .e1_ref_o(e1_ref), .t1_ref_o(t1_ref));
    liucfg_top liucfg_top_inst (
        .clock_i(clock_i), .reset_i(reset_i), .host_mode_i(host_mode), .cfg_wr_i(wr), .cfg_chan_i(chan),
        .cfg_data_i(data), .hw_cfg_i(hw), .rx_term_pin_override_i(term_ovr), .rx_term_pin_i(term_pin),
        .master_rate_bit_i(rate), .ref_freq_select_b2_i(sel[2]), .ref_freq_select_b1_i(sel[1]),
        .ref_freq_select_b0_i(sel[0]), .e1_ref_clock_in_i(e1_ref), .t1_ref_clock_in_i(t1_ref),
        .ch_cfg_o(ch_cfg), .ch_term_ohm_o(term_ohm), .ch_ext_res_ohm_o(ext_ohm), .line_rate_t1_o(rate_t1),
        .master_clk_o(mclk), .clk_sel_valid_o(sel_ok), .ref_lost_o(lost));

    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #10;
    endtask
    task automatic chk_cfg(input liucfg_chan_t got, input liucfg_chan_t exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: cfg %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: value %h want %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    function automatic liucfg_chan_t host_word(input int i);
        liucfg_chan_t d;
        d = CHAN_RESET;
        d.termination_impedance_sel = 2'(i);
        d.ext_resistor_sel = ~2'(i);
        d.equalizer_pulse_ctrl = 5'(i + 3);
        d.rx_termination_enable = i[0];
        d.qrss_enable = 1'b1;
        d.loopback = LOOP_DUAL;
        return d;
    endfunction

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic test_reset;
        for (int i = 0; i < NUM_CH; i++) begin
            chk_val(ch_cfg[i].rx_termination_enable, 0);
            chk_val(ch_cfg[i].ext_resistor_sel, EXT_RES_NONE);
            chk_val(ext_ohm[i], OHM_NONE);
        end
        $display("test reset done");
    endtask
    task automatic test_host;
        // writes go back to back, one channel per edge
        for (int i = 0; i < NUM_CH; i++) begin
            wr = 1'b1;
            chan = 3'(i);
            data = host_word(i);
            tick(1);
        end
        wr = 1'b0;
        tick(3);
        for (int i = 0; i < NUM_CH; i++) begin
            chk_cfg(ch_cfg[i], host_word(i));
            chk_val(term_ohm[i], term_tab[i % 4]);
            chk_val(ext_ohm[i], ext_tab[3 - i % 4]);
        end
        chk_val(rate_t1, 0);
        $display("test host done");
    endtask
    task automatic test_hw;
        liucfg_chan_t e;
        host_mode = 1'b0;
        hw = '{2'h2, 2'h3, 5'h15, 2'h2, 1'b1, 1'b1, 1'b1, 1'b1, LOOP_DUAL};
        wr = 1'b1;
        chan = 3'h0;
        data = CHAN_RESET;
        tick(1);
        wr = 1'b0;
        tick(3);
        e = hw;
        e.qrss_enable = 1'b0;
        e.loopback = LOOP_NONE;
        for (int i = 0; i < NUM_CH; i++) begin
            chk_cfg(ch_cfg[i], e);
            chk_val(term_ohm[i], OHM_120);
            chk_val(ext_ohm[i], OHM_210);
        end
        for (int l = 1; l < 4; l++) begin
            hw.loopback = liucfg_loop_t'(l);
            tick(2);
            chk_val(ch_cfg[5].loopback, 3'(l));
        end
        host_mode = 1'b1;
        tick(3);
        chk_cfg(ch_cfg[0], host_word(0));
        $display("test hardware done");
    endtask
    task automatic test_override;
        term_ovr = 1'b1;
        for (int p = 0; p < 2; p++) begin
            term_pin = p[0];
            tick(2);
            for (int i = 0; i < NUM_CH; i++) chk_val(ch_cfg[i].rx_termination_enable, p);
        end
        term_ovr = 1'b0;
        term_pin = 1'b1;
        tick(2);
        for (int i = 0; i < NUM_CH; i++) chk_val(ch_cfg[i].rx_termination_enable, i % 2);
        host_mode = 1'b0;
        tick(2);
        term_pin = 1'b0;
        tick(2);
        for (int i = 0; i < NUM_CH; i++) begin
            chk_val(ch_cfg[i].rx_termination_enable, hw.rx_termination_enable);
        end
        term_ovr = 1'b1;
        tick(2);
        for (int i = 0; i < NUM_CH; i++) chk_val(ch_cfg[i].rx_termination_enable, 0);
        term_ovr = 1'b0;
        host_mode = 1'b1;
        tick(2);
        $display("test override done");
    endtask
    task automatic test_clock;
        int cnt;
        logic prev;
        for (int k = 0; k < 4; k++) begin
            sel = 3'(k / 2);
            // one rate for the whole device
            rate = k[0];
            e1_en = ~sel[0];
            t1_en = sel[0];
            tick(4);
            cnt = 0;
            prev = mclk;
            repeat (1000) begin
                tick(1);
                if (mclk === 1'b1 && prev === 1'b0) cnt++;
                prev = mclk;
            end
            chk_val(rate ? (cnt >= 153 && cnt <= 156) : (cnt >= 203 && cnt <= 206), 1);
            chk_val(sel_ok, 1);
            chk_val(rate_t1, rate);
        end
        sel = 3'h2;
        tick(3);
        chk_val(sel_ok, 0);
        sel = 3'h0;
        e1_en = 1'b0;
        tick(20);
        chk_val(lost, 1);
        prev = mclk;
        tick(10);
        chk_val(mclk, prev);
        e1_en = 1'b1;
        tick(20);
        chk_val(lost, 0);
        $display("test clock done");
    endtask

    initial begin
        tick(1);
        test_reset();
        tick(2);
        reset_i = 1'b0;
        tick(2);
        test_host();
        test_hw();
        test_override();
        test_clock();
        results();
    end
endmodule
